// ---- rtl/pbled_pkg.sv ----
// Purpose: Constants and types for the pushbutton sequence decoder and status LED driver.
// Assumes: i_mclk runs at 100 MHz; times are counted in milliseconds.
// Notes: Blink on and off times are parameters because no exact values are fixed.
//
// How it works
// - Short pulse is high for 100 to 2000 ms.
// - One short pulse starts or cancels join.
// - Thirty second hold starts key generation.
// - Three short pulses start key test.
// - Four short pulses then 3 s hold resets.
// - Blink groups of three while reset hold continues.
// - On release, restore factory settings then restart.
// - Bad timing discarded; retry after 3 s low.
// - Otherwise LED follows the pushbutton line.
// - Administrator search shows repeating double quick blink.
// - Node search shows repeating single quick blink.
// - Key transfer shows repeating quick blink.
// - Transfer done shows six slow blinks.
// - Join cancel outside admin or node search shows two quick blinks once.
// - Pairing failure shows three slow blinks.
// - Long hold shows slow plus two quick blinks.
// - Key test shows one, two, three blinks thrice.
// - Idle LED off, on during radio activity.
package pbled_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned MS_PER_S = 1000;
	localparam logic [16:0] MS_CYCLES = 17'(CLK_HZ / MS_PER_S);
	localparam logic [15:0] SHORT_MIN_MS = 16'd100;
	localparam logic [15:0] SHORT_MAX_MS = 16'd2000;
	localparam logic [15:0] GAP_MIN_MS = 16'd100;
	localparam logic [15:0] GAP_MAX_MS = 16'd2000;
	localparam logic [15:0] KEYGEN_HOLD_MS = 16'd30000;
	localparam logic [15:0] RESET_HOLD_MS = 16'd3000;
	localparam logic [15:0] RETRY_LOW_MS = 16'd3000;
	localparam logic [15:0] JOIN_SHOW_MS = 16'd30000;
	localparam logic [15:0] QUICK_ON_MS = 16'd100;
	localparam logic [15:0] QUICK_OFF_MS = 16'd150;
	localparam logic [15:0] SLOW_ON_MS = 16'd500;
	localparam logic [15:0] SLOW_OFF_MS = 16'd500;
	localparam logic [15:0] GROUP_GAP_MS = 16'd600;
	localparam logic [2:0] PRESS_JOIN = 3'h1;
	localparam logic [2:0] PRESS_TEST = 3'h3;
	localparam logic [2:0] PRESS_RESET = 3'h4;
	localparam logic [3:0] SIX_BLINKS = 4'h6;
	localparam logic [3:0] THREE_TIMES = 4'h3;
	localparam logic [1:0] KEY_NONE = 2'h0;
	localparam logic [1:0] KEY_NODE = 2'h1;
	localparam logic [1:0] KEY_ADMIN = 2'h2;

	typedef enum logic [4:0] {
		PB_IDLE = 5'h01,
		PB_HIGH = 5'h02,
		PB_LOW = 5'h04,
		PB_LONG = 5'h08,
		PB_LOCK = 5'h10
	} pbled_pb_t;

	typedef enum logic [7:0] {
		SH_NONE = 8'h01,
		SH_ADMIN = 8'h02,
		SH_NODE = 8'h04,
		SH_XFER = 8'h08,
		SH_DONE = 8'h10,
		SH_CANCEL = 8'h20,
		SH_FAIL = 8'h40,
		SH_KTEST = 8'h80
	} pbled_show_t;

	typedef struct packed {
		logic join_admin;
		logic join_node;
		logic xfer_active;
		logic xfer_done;
		logic fail;
		logic activity;
		logic join_busy;
		logic [1:0] key_state;
	} pbled_stat_t;

	typedef struct packed {
		logic join_toggle;
		logic keygen;
		logic key_test;
		logic factory_restore;
		logic restart;
	} pbled_req_t;
endpackage : pbled_pkg

// ---- rtl/pbled_top.sv ----
// Purpose: Decode pushbutton press sequences and drive the status LED line.
// Assumes: Pushbutton line is asynchronous; status inputs come from i_mclk logic.
// Notes: Request outputs are one-cycle pulses from flip-flops.
`timescale 1ns/1ns
module pbled_top
	import pbled_pkg::*;
#(
	parameter logic [15:0] P_QUICK_ON_MS = QUICK_ON_MS,
	parameter logic [15:0] P_QUICK_OFF_MS = QUICK_OFF_MS,
	parameter logic [15:0] P_SLOW_ON_MS = SLOW_ON_MS,
	parameter logic [15:0] P_SLOW_OFF_MS = SLOW_OFF_MS,
	parameter logic [16:0] P_MS_CYCLES = MS_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_pushbutton_line,
	input wire pbled_stat_t i_stat,
	output pbled_req_t o_req,
	output logic o_status_led_line
);

	////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic pb_prev;
		logic [16:0] div;
		logic tick;
		pbled_pb_t pb;
		logic [15:0] ivl;
		logic [2:0] presses;
		logic reset_armed;
		logic keygen_armed;
		pbled_req_t req;
		pbled_show_t show;
		logic [15:0] show_ms;
		logic [15:0] seg_ms;
		logic seg_on;
		logic [3:0] blink;
		logic [3:0] group;
		logic [3:0] groups;
		logic [3:0] grp_len;
		logic led;
		logic join_prev;
	} pbled_state_t;

	pbled_state_t st;
	pbled_state_t next_st;

	function automatic logic is_short(input logic [15:0] ms);
		is_short = (ms >= SHORT_MIN_MS) && (ms <= SHORT_MAX_MS);
	endfunction : is_short

	function automatic logic is_gap(input logic [15:0] ms);
		is_gap = (ms >= GAP_MIN_MS) && (ms <= GAP_MAX_MS);
	endfunction : is_gap

	function automatic logic [15:0] sat_inc(input logic [15:0] v);
		sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
	endfunction : sat_inc

	////////////////////////////////////////////////////////////////////////
	// Next state.

	logic pb_s;
	logic rise;
	logic fall;
	logic [15:0] on_ms;
	logic [15:0] off_ms;
	logic quick;
	logic seg_end;

	always_comb begin
		next_st = st;
		next_st.req = '0;
		next_st.tick = 1'b0;
		pb_s = st.sync2;
		rise = pb_s && !st.pb_prev;
		fall = !pb_s && st.pb_prev;
		// Synchroniser and millisecond tick.
		next_st.sync1 = i_pushbutton_line;
		next_st.sync2 = st.sync1;
		next_st.pb_prev = st.sync2;
		if (st.div >= P_MS_CYCLES - 17'h00001) begin
			next_st.div = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.div = st.div + 17'h00001;
		end
		if (st.tick) begin
			next_st.ivl = sat_inc(st.ivl);
		end
		if (rise || fall) begin
			next_st.ivl = '0;
		end

		// Press sequence decoder.
		case (st.pb)
			PB_IDLE: begin
				next_st.presses = '0;
				if (rise) begin
					next_st.pb = PB_HIGH;
				end
			end
			PB_HIGH: begin
				if (st.presses == PRESS_RESET && st.ivl > RESET_HOLD_MS) begin
					next_st.reset_armed = 1'b1;
					next_st.pb = PB_LONG;
				end else if (st.presses == '0 && st.ivl >= KEYGEN_HOLD_MS) begin
					next_st.keygen_armed = 1'b1;
					next_st.pb = PB_LONG;
				end else if (fall) begin
					if (is_short(st.ivl) && st.presses < PRESS_RESET) begin
						next_st.presses = st.presses + 3'h1;
						next_st.pb = PB_LOW;
					end else begin
						next_st.pb = PB_LOCK;
					end
				end
			end
			PB_LOW: begin
				if (rise) begin
					next_st.pb = is_gap(st.ivl) ? PB_HIGH : PB_LOCK;
				end else if (st.ivl > GAP_MAX_MS) begin
					next_st.pb = PB_LOCK;
					if (st.presses == PRESS_JOIN) begin
						next_st.req.join_toggle = 1'b1;
						next_st.pb = PB_IDLE;
					end else if (st.presses == PRESS_TEST) begin
						next_st.req.key_test = 1'b1;
						next_st.pb = PB_IDLE;
					end
				end
			end
			PB_LONG: begin
				if (fall) begin
					next_st.req.keygen = st.keygen_armed;
					next_st.req.factory_restore = st.reset_armed;
					next_st.req.restart = st.reset_armed;
					next_st.keygen_armed = 1'b0;
					next_st.reset_armed = 1'b0;
					next_st.pb = PB_IDLE;
				end
			end
			PB_LOCK: begin
				if (pb_s) begin
					next_st.ivl = '0;
				end else if (st.ivl >= RETRY_LOW_MS) begin
					next_st.pb = PB_IDLE;
				end
			end
			default: begin
				next_st.pb = PB_IDLE;
			end
		endcase

		// Pattern selection, fixed priority, failure first.
		next_st.join_prev = i_stat.join_busy;
		if (i_stat.fail) begin
			next_st.show = SH_FAIL;
			next_st.groups = THREE_TIMES;
			next_st.grp_len = 4'h1;
		end else if (i_stat.xfer_done) begin
			next_st.show = SH_DONE;
			next_st.groups = SIX_BLINKS;
			next_st.grp_len = 4'h1;
		end else if (st.join_prev && !i_stat.join_busy && !i_stat.xfer_active) begin
			next_st.show = SH_CANCEL;
			next_st.groups = 4'h1;
			next_st.grp_len = 4'h2;
		end else if (st.req.key_test) begin
			next_st.show = SH_KTEST;
			next_st.groups = THREE_TIMES;
			next_st.grp_len = (i_stat.key_state == KEY_ADMIN) ? 4'h3 :
				(i_stat.key_state == KEY_NODE) ? 4'h2 : 4'h1;
		end else if (i_stat.xfer_active) begin
			next_st.show = SH_XFER;
			next_st.groups = '0;
			next_st.grp_len = 4'h1;
		end else if (st.show == SH_NONE && i_stat.join_admin) begin
			next_st.show = SH_ADMIN;
			next_st.groups = '0;
			next_st.grp_len = 4'h2;
		end else if (st.show == SH_NONE && i_stat.join_node) begin
			next_st.show = SH_NODE;
			next_st.groups = '0;
			next_st.grp_len = 4'h1;
		end
		if (next_st.show != st.show || st.req.key_test) begin
			next_st.show_ms = '0;
			next_st.seg_ms = '0;
			next_st.seg_on = 1'b1;
			next_st.blink = '0;
			next_st.group = '0;
		end

		// Blink generator.
		quick = !(st.show == SH_DONE || st.show == SH_FAIL);
		on_ms = quick ? P_QUICK_ON_MS : P_SLOW_ON_MS;
		off_ms = quick ? P_QUICK_OFF_MS : P_SLOW_OFF_MS;
		if (st.pb == PB_LONG) begin
			on_ms = (st.blink == '0) ? P_SLOW_ON_MS : P_QUICK_ON_MS;
			off_ms = (st.blink == '0) ? P_SLOW_OFF_MS : P_QUICK_OFF_MS;
		end
		if (st.blink == st.grp_len - 4'h1 && !st.seg_on) begin
			off_ms = off_ms + GROUP_GAP_MS;
		end
		seg_end = st.tick && (st.seg_ms + 16'h0001 >= (st.seg_on ? on_ms : off_ms));
		if (st.pb == PB_LONG && st.pb != next_st.pb) begin
			next_st.blink = '0;
			next_st.seg_on = 1'b1;
			next_st.seg_ms = '0;
		end else if (st.pb != PB_LONG && next_st.pb == PB_LONG) begin
			next_st.grp_len = next_st.reset_armed ? 4'h3 : 4'h3;
			next_st.blink = '0;
			next_st.seg_on = 1'b1;
			next_st.seg_ms = '0;
		end else if (st.tick && st.show != next_st.show) begin
			next_st.seg_ms = '0;
		end else if (seg_end) begin
			next_st.seg_ms = '0;
			next_st.seg_on = !st.seg_on;
			if (!st.seg_on) begin
				if (st.blink >= st.grp_len - 4'h1) begin
					next_st.blink = '0;
					next_st.group = st.group + 4'h1;
					if (st.groups != '0 && st.group + 4'h1 >= st.groups) begin
						next_st.show = SH_NONE;
					end
				end else begin
					next_st.blink = st.blink + 4'h1;
				end
			end
		end else if (st.tick) begin
			next_st.seg_ms = st.seg_ms + 16'h0001;
		end
		if (st.tick && next_st.show == st.show) begin
			next_st.show_ms = sat_inc(st.show_ms);
		end
		if (st.show == SH_ADMIN || st.show == SH_NODE) begin
			if (st.show_ms >= JOIN_SHOW_MS || !i_stat.join_busy) begin
				next_st.show = SH_NONE;
			end
		end
		if (st.show == SH_XFER && !i_stat.xfer_active) begin
			next_st.show = SH_NONE;
		end

		// LED output.
		if (st.pb == PB_LONG) begin
			next_st.led = st.seg_on;
		end else if (st.show != SH_NONE) begin
			next_st.led = st.seg_on;
		end else if (pb_s) begin
			next_st.led = 1'b1;
		end else begin
			next_st.led = i_stat.activity;
		end

		if (i_rst) begin
			next_st = '0;
			next_st.pb = PB_IDLE;
			next_st.show = SH_NONE;
		end
	end

	always_ff @(posedge i_mclk) begin
		st <= next_st;
	end

	assign o_req = st.req;
	assign o_status_led_line = st.led;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_long_release;
		(st.pb == PB_LONG && st.reset_armed) ##1 (st.pb == PB_LONG && fall);
	endsequence

	sequence s_keygen_release;
		(st.pb == PB_LONG && st.keygen_armed) ##1 (st.pb == PB_LONG && fall);
	endsequence

	chk_short_class: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st.pb == PB_HIGH && fall && st.ivl < SHORT_MIN_MS) |=> (st.pb == PB_LOCK))
		else $error("Too short pulse was accepted.");
	chk_join_pulse: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_req.join_toggle |-> $past(st.presses) == PRESS_JOIN)
		else $error("Join request without a single press.");
	chk_test_pulse: assert property (@(posedge i_mclk) disable iff (i_rst)
		o_req.key_test |-> $past(st.presses) == PRESS_TEST)
		else $error("Key test request without three presses.");
	chk_reset_arm: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(st.reset_armed) |-> $past(st.presses) == PRESS_RESET)
		else $error("Reset armed without four presses.");
	chk_restore_fall: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_long_release |=> (o_req.factory_restore && o_req.restart))
		else $error("Factory restore missing after release.");
	chk_lock_low: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st.pb == PB_LOCK && $past(pb_s)) |=> st.pb != PB_IDLE)
		else $error("Retry accepted too soon after high line.");
	chk_led_follow: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st.pb != PB_LONG && st.show == SH_NONE && pb_s) |=> o_status_led_line)
		else $error("LED not on while line is high.");
	chk_idle_off: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st.pb == PB_IDLE && st.show == SH_NONE && !pb_s && !i_stat.activity)
		|=> !o_status_led_line)
		else $error("LED on while idle.");
	chk_long_pulse: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st.pb == PB_HIGH && fall && st.ivl > SHORT_MAX_MS && st.ivl <= RESET_HOLD_MS)
		|=> (st.pb == PB_LOCK))
		else $error("Too long pulse was accepted.");
	chk_keygen_arm: assert property (@(posedge i_mclk) disable iff (i_rst)
		$rose(st.keygen_armed) |-> ($past(st.presses) == 3'h0 &&
		$past(st.ivl) >= KEYGEN_HOLD_MS))
		else $error("Key generation armed without a full hold.");
	chk_keygen_rel: assert property (@(posedge i_mclk) disable iff (i_rst)
		s_keygen_release |=> (o_req.keygen && !o_req.factory_restore))
		else $error("Key generation request missing after release.");
	chk_gap_short: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st.pb == PB_LOW && rise && st.ivl < GAP_MIN_MS) |=> (st.pb == PB_LOCK))
		else $error("Too short gap was accepted.");
	chk_fifth_press: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st.pb == PB_HIGH && fall && st.presses == PRESS_RESET && st.ivl <= RESET_HOLD_MS)
		|=> (st.pb == PB_LOCK))
		else $error("Fifth press was accepted.");
	chk_lock_exit: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st.pb == PB_LOCK && !pb_s && st.ivl >= RETRY_LOW_MS) |=> (st.pb == PB_IDLE))
		else $error("Lock not left after a long low line.");
	chk_sync_two: assert property (@(posedge i_mclk) disable iff (i_rst)
		(!$past(i_rst) && !$past(i_rst, 2)) |-> (pb_s == $past(i_pushbutton_line, 2)))
		else $error("Pushbutton synchroniser delay is wrong.");
	chk_fail_show: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st.show == SH_NONE && i_stat.fail) |=> (st.show == SH_FAIL))
		else $error("Failure pattern not started.");
	chk_done_show: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st.show == SH_NONE && i_stat.xfer_done && !i_stat.fail) |=> (st.show == SH_DONE))
		else $error("Transfer done pattern not started.");
	chk_cancel_show: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st.show == SH_NONE && st.join_prev && !i_stat.join_busy && !i_stat.xfer_active &&
		!i_stat.fail && !i_stat.xfer_done) |=> (st.show == SH_CANCEL))
		else $error("Cancel pattern not started.");
	chk_xfer_end: assert property (@(posedge i_mclk) disable iff (i_rst)
		(st.show == SH_XFER && !i_stat.xfer_active) |=> (st.show == SH_NONE))
		else $error("Transfer pattern outlived the transfer.");
	chk_join_end: assert property (@(posedge i_mclk) disable iff (i_rst)
		((st.show == SH_ADMIN || st.show == SH_NODE) && !i_stat.join_busy)
		|=> (st.show == SH_NONE))
		else $error("Join pattern outlived the join.");
	chk_test_show: assert property (@(posedge i_mclk) disable iff (i_rst)
		(o_req.key_test && !i_stat.fail && !i_stat.xfer_done &&
		!(st.join_prev && !i_stat.join_busy && !i_stat.xfer_active) &&
		st.show != SH_XFER && st.show != SH_ADMIN && st.show != SH_NODE)
		|=> (st.show == SH_KTEST))
		else $error("Key test pattern not started.");
endmodule : pbled_top

// ---- sim/pbled_partner.sv ----
// Purpose: Pushbutton and indicator LED model.
// Assumes: The line is pulled low while the button is released.
// Notes: One millisecond is MSC clock cycles.
`timescale 1ns/1ns
module pbled_partner #(
	parameter int MSC = 1
) (
	input wire logic i_mclk,
	input wire logic i_led,
	output logic o_line
);
	int led_rises = 0;
	logic led_prev = 1'h0;
	initial o_line = 1'h0;
	////////////////////////////////////////
	// Counts LED turn-on edges away from the launching edge.
	always @(negedge i_mclk) begin
		led_prev <= i_led;
		if (i_led === 1'h1 && led_prev === 1'h0) begin
			led_rises <= led_rises + 1;
		end
	end
	// Drives the line for a number of milliseconds from the next edge.
	task automatic hold(input logic lvl, input int ms);
		@(posedge i_mclk);
		o_line <= lvl;
		repeat (ms * MSC - 1) @(posedge i_mclk);
	endtask : hold
endmodule : pbled_partner

// ---- sim/pbled_top_tb.sv ----
// Purpose: Self-checking bench for the pushbutton decoder and LED driver.
// Assumes: One millisecond tick is one clock cycle.
// Notes: Request pulses and LED turn-ons are counted over each scenario.
`timescale 1ns/1ns
module pbled_top_tb;
	import pbled_pkg::*;
	localparam int MSC = 1;
	logic i_mclk;
	logic i_rst;
	logic line;
	pbled_stat_t i_stat;
	pbled_req_t o_req;
	logic o_status_led_line;
	int fail_count = 0;
	int check_count = 0;
	int n_req[5] = '{default: 0};
	int b_req[5];
	int n_pair = 0;
	int b_pair;
	int b_led;
	pbled_top #(.P_MS_CYCLES(17'(MSC))) dut (.i_mclk(i_mclk), .i_rst(i_rst),
		.i_pushbutton_line(line), .i_stat(i_stat), .o_req(o_req),
		.o_status_led_line(o_status_led_line));
	pbled_partner #(.MSC(MSC)) btn (.i_mclk(i_mclk), .i_led(o_status_led_line), .o_line(line));
	////////////////////////////////////////
	initial begin
		i_mclk = 1'h0;
		forever #5 i_mclk = ~i_mclk;
	end
	// Counts request pulses; bit 4 join, 3 keygen, 2 test, 1 restore, 0 restart.
	always @(negedge i_mclk) begin
		for (int i = 0; i < 5; i++) begin
			if (o_req[i] === 1'h1) n_req[i] <= n_req[i] + 1;
		end
		if (o_req.factory_restore === 1'h1 && o_req.restart === 1'h1) n_pair <= n_pair + 1;
	end
	task automatic report_and_stop();
		if (fail_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %0d seen %0d", nm, exp, seen);
		end
	endtask : check
	task automatic mark();
		b_req = n_req;
		b_pair = n_pair;
		b_led = btn.led_rises;
	endtask : mark
	function automatic logic [31:0] dr(input int i);
		return 32'(n_req[i] - b_req[i]);
	endfunction : dr
	function automatic logic [31:0] dl();
		return 32'(btn.led_rises - b_led);
	endfunction : dl
	////////////////////////////////////////
	task automatic t_act();
		@(posedge i_mclk);
		i_stat.activity <= 1'h1;
		repeat (5) @(posedge i_mclk);
		@(negedge i_mclk);
		check("led busy", 32'(o_status_led_line), 32'h1);
		@(posedge i_mclk);
		i_stat.activity <= 1'h0;
		repeat (5) @(posedge i_mclk);
		@(negedge i_mclk);
		check("led idle", 32'(o_status_led_line), 32'h0);
	endtask : t_act
	task automatic t_single();
		mark();
		btn.hold(1'h1, 150);
		@(negedge i_mclk);
		check("led press", 32'(o_status_led_line), 32'h1);
		btn.hold(1'h0, 2600);
		check("join", dr(4), 32'h1);
		check("no test", dr(2), 32'h0);
	endtask : t_single
	task automatic t_reject();
		mark();
		btn.hold(1'h1, 50);
		btn.hold(1'h0, 1000);
		btn.hold(1'h1, 150);
		btn.hold(1'h0, 3100);
		check("join locked", dr(4), 32'h0);
		btn.hold(1'h1, 150);
		btn.hold(1'h0, 2600);
		check("join retry", dr(4), 32'h1);
	endtask : t_reject
	task automatic t_test(input logic [1:0] ks, input int blinks);
		@(posedge i_mclk);
		i_stat.key_state <= ks;
		mark();
		repeat (3) begin
			btn.hold(1'h1, 200);
			btn.hold(1'h0, 200);
		end
		b_led = btn.led_rises;
		btn.hold(1'h0, 6300);
		check("key test", dr(2), 32'h1);
		check("test no join", dr(4), 32'h0);
		check("test blinks", dl(), 32'(blinks));
	endtask : t_test
	task automatic t_factory();
		mark();
		repeat (4) begin
			btn.hold(1'h1, 300);
			btn.hold(1'h0, 300);
		end
		btn.hold(1'h1, 3100);
		b_led = btn.led_rises;
		btn.hold(1'h1, 3000);
		check("reset blinks", 32'(dl() >= 2), 32'h1);
		check("restore early", dr(1), 32'h0);
		btn.hold(1'h0, 20);
		check("restore", dr(1), 32'h1);
		check("restore pair", 32'(n_pair - b_pair), 32'h1);
		check("no keygen", dr(3), 32'h0);
		btn.hold(1'h0, 3100);
	endtask : t_factory
	task automatic t_keygen();
		mark();
		btn.hold(1'h1, 30100);
		b_led = btn.led_rises;
		btn.hold(1'h1, 2400);
		check("hold blinks", 32'(dl() >= 2), 32'h1);
		btn.hold(1'h0, 20);
		check("keygen", dr(3), 32'h1);
		check("no restore", dr(1), 32'h0);
		btn.hold(1'h0, 3100);
	endtask : t_keygen
	task automatic t_show(input pbled_stat_t st, input int on_ms, input int wait_ms);
		mark();
		@(posedge i_mclk);
		i_stat <= st;
		repeat (on_ms * MSC) @(posedge i_mclk);
		i_stat <= '0;
		repeat (wait_ms * MSC) @(posedge i_mclk);
	endtask : t_show
	////////////////////////////////////////
	initial begin
		i_rst = 1'h1;
		i_stat = '0;
		repeat (6) @(posedge i_mclk);
		@(negedge i_mclk);
		check("req in reset", 32'(o_req), 32'h0);
		check("led in reset", 32'(o_status_led_line), 32'h0);
		@(posedge i_mclk);
		i_rst <= 1'h0;
		t_act();
		t_single();
		t_reject();
		t_test(KEY_NONE, 3);
		t_test(KEY_NODE, 6);
		t_test(KEY_ADMIN, 9);
		t_factory();
		t_keygen();
		t_show(9'h020, 1, 10000);
		check("done blinks", dl(), 32'h6);
		t_show(9'h010, 1, 5000);
		check("fail blinks", dl(), 32'h3);
		t_show(9'h004, 10, 2000);
		check("cancel blinks", dl(), 32'h2);
		t_show(9'h040, 2000, 500);
		check("xfer blinks", 32'(dl() >= 3), 32'h1);
		t_show(9'h104, 1000, 1500);
		check("admin blinks", 32'(dl() >= 2), 32'h1);
		t_show(9'h084, 1000, 500);
		check("node blinks", 32'(dl() >= 2), 32'h1);
		report_and_stop();
	end
	initial begin
		repeat (130000) @(posedge i_mclk);
		fail_count++;
		report_and_stop();
	end
endmodule : pbled_top_tb
